// ---- hdl/vcs_clock_select.sv ----
// Purpose: frequency select latch, table, dividers, reset sequence
// Assumes: pins synchronous to clk; clk stands for the main clock
// Notes on behaviour
// RQ1: strobe high passes selects straight through
// RQ2: strobe low holds last selection
// RQ3: reset with strobe low uses entry 0
// RQ4: unconnected select and strobe read high
// RQ5: 32 entries, first select is LSB
// RQ6: entry gives feedback, reference, gain values
// RQ7: dual-modulus feedback counter, steps of one
// RQ8: post divider set per entry
// RQ9: load moduli 3,4,5,6,8,10
// RQ10: load clock 50/50 even for odd moduli
// RQ11: load modulus comes from selected entry
// RQ12: load clock is main clock over modulus
// RQ13: entry may hold load clock low
// RQ14: strobe rise starts pipeline reset sequence
// RQ15: host toggles strobe in transparent use
// RQ16: host reloads same selection when latched
// RQ17: host waits 500 us before reset
// RQ18: oscillator is ref times fb over ref
// RQ19: sequence is parameterized stop and pulses
// RQ20: latch tracks while high, freezes on fall
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module vcs_clock_select
  import vcs_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [vcs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Select pins and their connection state
  input wire logic [vcs_pkg::SEL_W-1:0] freq_select_bits,
  input wire logic [vcs_pkg::SEL_W-1:0] fs_driven,
  input wire logic strobe,
  input wire logic strobe_driven,
  // Synthesizer settings
  output logic [vcs_pkg::FB_W-1:0] fb_div_out,
  output logic [vcs_pkg::REF_W-1:0] ref_div_out,
  output logic [vcs_pkg::VCO_W-1:0] vco_gain_out,
  output logic [vcs_pkg::POST_W-1:0] post_div_out,
  // Divider ticks, load clock and sequence busy
  output logic fb_tick,
  output logic ref_tick,
  output logic load_clock_out,
  output logic pipe_seq_busy
);
  import vcs_pkg::*;

  // -------------------------------------
  // Pins with pull-ups
  // -------------------------------------
  // Undriven pin floats high
  wire [SEL_W-1:0] fs_in = freq_select_bits | ~fs_driven; // see RQ4
  wire strobe_in = strobe | ~strobe_driven; // see RQ4

  // -------------------------------------
  // Selection latch
  // -------------------------------------
  logic [SEL_W-1:0] sel_q; // Latched address
  logic strb_q; // Strobe last cycle
  // Transparent path while strobe high
  wire [SEL_W-1:0] eff_sel = strobe_in ? fs_in : sel_q; // see RQ1 RQ2
  wire strobe_rise = strobe_in & ~strb_q;

  // Track while high, freeze when low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sel_q <= '0; // see RQ3
      strb_q <= 1'b1; // No false edge at release
    end
    else if (ce)
    begin
      if (strobe_in)
        sel_q <= fs_in; // see RQ20
      strb_q <= strobe_in;
    end
  end

  chk_latch_track: assert property (@(posedge clk) disable iff (srst)
    ce && strobe_in |=> sel_q == $past(fs_in)) // see RQ20
    else $error("latch did not track select");
  chk_latch_hold: assert property (@(posedge clk) disable iff (srst)
    ce && !strobe_in |=> $stable(sel_q)) // see RQ2
    else $error("latched select changed");
  chk_reset_addr: assert property (@(posedge clk)
    $past(srst) |-> sel_q == '0) // see RQ3
    else $error("select not zero after reset");
  chk_pull_up: assert property (@(posedge clk) disable iff (srst)
    !strobe_driven |-> (eff_sel | fs_driven) == '1) // see RQ4
    else $error("floating strobe not high");

  // -------------------------------------
  // Frequency table and bus slave
  // -------------------------------------
  logic [ENTRY_W-1:0] tbl_q [NUM_ENTRIES]; // Writable table
  logic [ENTRY_W-1:0] entry_q; // Entry in use
  logic [1:0] ctrl_q; // Force suppress, trigger
  logic resp_q; // Second bus cycle
  vcs_seq_e seq_q;

  // One wait state on every access
  wire bus_req = avs_read | avs_write;
  wire bus_go = bus_req & resp_q;
  wire is_tbl = avs_address[TBL_SEL_BIT];
  wire [SEL_W-1:0] tbl_idx = avs_address[6:2];
  wire is_ctrl = ~is_tbl & (avs_address == CTRL_OFS);
  wire is_stat = ~is_tbl & (avs_address == STAT_OFS);
  wire wr_tbl = bus_go & avs_write & is_tbl;
  wire wr_ctrl = bus_go & avs_write & is_ctrl;
  wire sw_trig = ctrl_q[CTRL_TRIG_BIT];
  wire [3:0] ld_div = vcs_mod_div(entry_q[MODC_LSB +: MODC_W]);
  // Status view
  wire [31:0] stat_w = {12'h000, ld_div, 7'h00,
    (seq_q != SQ_IDLE), 3'h0, eff_sel};
  // Unmapped offsets read zero
  wire [31:0] rd_mux = is_tbl ? {6'h00, tbl_q[tbl_idx]} :
    is_ctrl ? {30'h0, ctrl_q} :
    is_stat ? stat_w : 32'h0;

  assign avs_waitrequest = bus_req & ~resp_q;

  // Bus handshake and read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      resp_q <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl_q <= 2'h0;
    end
    else if (ce)
    begin
      resp_q <= bus_req & ~resp_q;
      if (bus_req & ~resp_q)
        avs_readdata <= rd_mux;
      // Trigger bit clears itself
      if (wr_ctrl)
        ctrl_q <= avs_writedata[1:0];
      else
        ctrl_q[CTRL_TRIG_BIT] <= 1'b0;
    end
  end

  // Table words, one per address
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi++)
    begin : g_tbl
      always_ff @(posedge clk)
      begin
        if (srst)
          tbl_q[gi] <= ENTRY_RST;
        else if (ce && wr_tbl && tbl_idx == gi)
          tbl_q[gi] <= avs_writedata[ENTRY_W-1:0]; // see RQ5
      end
    end
  endgenerate

  // Entry fetch; fields go out registered
  always_ff @(posedge clk)
  begin
    if (srst)
      entry_q <= ENTRY_RST;
    else if (ce)
      entry_q <= tbl_q[eff_sel]; // see RQ5 RQ11
  end

  assign fb_div_out = entry_q[FB_LSB +: FB_W]; // see RQ6
  assign ref_div_out = entry_q[REF_LSB +: REF_W]; // see RQ6 RQ18
  assign vco_gain_out = entry_q[VCO_LSB +: VCO_W]; // see RQ6
  assign post_div_out = entry_q[POST_LSB +: POST_W]; // see RQ8

  // -------------------------------------
  // Feedback divider, dual modulus
  // -------------------------------------
  // N = PRESC*M + A; A periods of PRESC+1 first
  logic [PRESC_W:0] pre_q; // Prescaler count
  logic [6:0] mc_q; // Main counter
  wire [6:0] fb_m = fb_div_out[FB_W-1:PRESC_W];
  wire [6:0] fb_a = {4'h0, fb_div_out[PRESC_W-1:0]};
  wire [6:0] m_last = (fb_m == 7'h0) ? 7'h0 : fb_m - 7'h1;
  // Swallow adds one count while mc below A
  wire [PRESC_W:0] pre_last = (mc_q < fb_a) ?
    (PRESC_W+1)'(PRESC) : (PRESC_W+1)'(PRESC - 1);
  wire pre_wrap = pre_q >= pre_last;
  wire mc_wrap = mc_q >= m_last;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pre_q <= '0;
      mc_q <= '0;
      fb_tick <= 1'b0;
    end
    else if (ce)
    begin
      pre_q <= pre_wrap ? '0 : pre_q + 1'b1; // see RQ7
      if (pre_wrap)
        mc_q <= mc_wrap ? 7'h0 : mc_q + 7'h1;
      fb_tick <= pre_wrap & mc_wrap;
    end
  end

  // -------------------------------------
  // Reference divider
  // -------------------------------------
  logic [REF_W-1:0] rc_q;
  wire rc_wrap = rc_q >= ref_div_out - 1'b1;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rc_q <= '0;
      ref_tick <= 1'b0;
    end
    else if (ce)
    begin
      rc_q <= rc_wrap ? '0 : rc_q + 1'b1; // see RQ18
      ref_tick <= rc_wrap;
    end
  end

  // -------------------------------------
  // Pipeline reset sequence
  // -------------------------------------
  logic [3:0] sq_cnt_q; // Cycles or pulses left
  logic [3:0] ld_cnt_q; // Load divider phase
  wire ld_wrap = ld_cnt_q >= ld_div - 4'h1;
  wire hold_ld = (seq_q == SQ_STOP);

  // Stop load clock, then count pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      seq_q <= SQ_IDLE;
      sq_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (strobe_rise | sw_trig)
      begin
        seq_q <= SQ_STOP; // see RQ14
        sq_cnt_q <= 4'(PRST_STOP_CYC - 1);
      end
      else
      begin
        unique case (seq_q)
          SQ_IDLE: ;
          SQ_STOP:
            if (sq_cnt_q == 4'h0)
            begin
              seq_q <= SQ_PULSE; // see RQ19
              sq_cnt_q <= 4'(PRST_PULSES - 1);
            end
            else
              sq_cnt_q <= sq_cnt_q - 4'h1;
          SQ_PULSE:
            if (ld_wrap)
            begin
              if (sq_cnt_q == 4'h0)
                seq_q <= SQ_IDLE;
              else
                sq_cnt_q <= sq_cnt_q - 4'h1;
            end
        endcase
      end
    end
  end

  assign pipe_seq_busy = (seq_q != SQ_IDLE);

  chk_seq_start: assert property (@(posedge clk) disable iff (srst)
    ce && strobe_rise |=> seq_q == SQ_STOP) // see RQ14
    else $error("strobe rise did not start sequence");
  chk_stop_len: assert property (@(posedge clk) disable iff (srst)
    $rose(seq_q == SQ_STOP) |-> (seq_q == SQ_STOP)[*8]) // see RQ19
    else $error("stop phase too short");

  // -------------------------------------
  // Load clock divider
  // -------------------------------------
  // Odd ratios use a falling-edge copy so high
  // time is exactly half; costs one negedge flop
  logic ld_p_q; // Rising-edge phase
  logic ld_n_q; // Half-cycle delayed phase
  wire [3:0] ld_half = (ld_div + 4'h1) >> 1;
  wire supp_any = entry_q[SUPP_BIT] | ctrl_q[CTRL_SUPP_BIT] | hold_ld;

  always_ff @(posedge clk)
  begin
    if (srst || (ce && hold_ld))
    begin
      ld_cnt_q <= '0;
      ld_p_q <= 1'b0;
    end
    else if (ce)
    begin
      ld_cnt_q <= ld_wrap ? 4'h0 : ld_cnt_q + 4'h1; // see RQ9 RQ12
      ld_p_q <= ld_cnt_q < ld_half;
    end
  end

  // Half-cycle shifted copy
  always_ff @(negedge clk)
  begin
    if (srst)
      ld_n_q <= 1'b0;
    else if (ce)
      ld_n_q <= ld_p_q; // see RQ10
  end

  // Odd: AND trims half a cycle off high time
  assign load_clock_out = supp_any ? 1'b0 : // see RQ13
    (ld_div[0] ? (ld_p_q & ld_n_q) : ld_p_q); // see RQ10

  chk_ld_supp: assert property (@(posedge clk) disable iff (srst)
    supp_any |-> !load_clock_out) // see RQ13
    else $error("suppressed load clock toggled");
  chk_ld_range: assert property (@(posedge clk) disable iff (srst)
    ce && !hold_ld && $stable(ld_div) |-> ld_cnt_q < ld_div) // see RQ12
    else $error("load counter beyond modulus");

endmodule // vcs_clock_select
`default_nettype wire

// ---- hdl/vcs_pkg.sv ----
// Purpose: constants for the video clock select block
// Assumes: one 100 MHz clock, Avalon-MM slave
// Notes: table entries are packed words
package vcs_pkg;
  // -------------------------------------
  // Table shape
  // -------------------------------------
  localparam int NUM_ENTRIES = 32;
  localparam int SEL_W = 5;
  localparam int FB_W = 10;
  localparam int REF_W = 7;
  localparam int VCO_W = 3;
  localparam int POST_W = 2;
  localparam int MODC_W = 3;
  localparam int FB_LSB = 0;
  localparam int REF_LSB = 10;
  localparam int VCO_LSB = 17;
  localparam int POST_LSB = 20;
  localparam int MODC_LSB = 22;
  localparam int SUPP_BIT = 25;
  localparam int ENTRY_W = 26;
  // fb 100, ref 10, gain 2, post 0, load /4
  localparam logic [25:0] ENTRY_RST = 26'h0442864;
  // -------------------------------------
  // Register map (byte addresses)
  // -------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int TBL_SEL_BIT = 7;
  localparam int CTRL_SUPP_BIT = 0;
  localparam int CTRL_TRIG_BIT = 1;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_MOD_LSB = 16;
  // -------------------------------------
  // Divider and sequence constants
  // -------------------------------------
  localparam int PRESC = 8;
  localparam int PRESC_W = 3;
  localparam int PRST_STOP_CYC = 8;
  localparam int PRST_PULSES = 4;
  // Pipeline reset sequence phases
  typedef enum logic [1:0] {SQ_IDLE, SQ_STOP, SQ_PULSE} vcs_seq_e;
  // Load modulus code to divide ratio
  function automatic logic [3:0] vcs_mod_div(input logic [2:0] c);
    unique case (c)
      3'h0: vcs_mod_div = 4'h3;
      3'h1: vcs_mod_div = 4'h4;
      3'h2: vcs_mod_div = 4'h5;
      3'h3: vcs_mod_div = 4'h6;
      3'h4: vcs_mod_div = 4'h8;
      default: vcs_mod_div = 4'ha;
    endcase
  endfunction
endpackage

// ---- test/vcs_ramdac_model.sv ----
// Purpose: receiver of the load clock
// Assumes: load clock arrives as a plain level
// Notes: measures period, high time and edge count
`timescale 1ns/1ns
`default_nettype none
module vcs_ramdac_model (
  // Load clock from the block
  input wire logic load_clk,
  // Measurements for the bench
  output int edges,
  output int period_ns,
  output int high_ns
);
  // Time of the last rising edge
  time rise_t = 0;
  initial edges = 0;
  // Rising edge: period and count
  always @(posedge load_clk)
  begin
    period_ns = int'($time - rise_t);
    rise_t = $time;
    edges = edges + 1;
  end
  // Falling edge: high time, for duty
  always @(negedge load_clk)
  begin
    high_ns = int'($time - rise_t);
  end
endmodule // vcs_ramdac_model
`default_nettype wire

// ---- test/video_clock_select_and_load_divider_tb_top.sv ----
// Purpose: self-checking bench for the clock select block
// Assumes: ce held high, bus answers after one wait state
// Notes: strobe and selects driven as the controller would
`timescale 1ns/1ns
`default_nettype none
module video_clock_select_and_load_divider_tb_top;
  import vcs_pkg::*;
  // ----------------------------------
  // Signals
  // ----------------------------------
  logic clk = 0, srst = 1, ce = 1, rd = 0, wr = 0, stb = 0, stbd = 1;
  logic wt, ld, busy, fbt, rft;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [4:0] fs = 5'h00, fsd = 5'h1f;
  logic [9:0] fb;
  logic [6:0] rf;
  logic [2:0] vg;
  logic [1:0] pd;
  int fails = 0, samples_checked = 0, cyc = 0, e, n;
  int fb_cnt = 0, fb_gap = 0, rf_cnt = 0, rf_gap = 0, edges, period_ns, high_ns;
  // Codes 6 and 7 fall back to divide by ten
  int dv[8] = '{3, 4, 5, 6, 8, 10, 10, 10};
  vcs_clock_select dut (.clk(clk), .srst(srst), .ce(ce), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wt), .freq_select_bits(fs), .fs_driven(fsd), .strobe(stb),
    .strobe_driven(stbd), .fb_div_out(fb), .ref_div_out(rf), .vco_gain_out(vg),
    .post_div_out(pd), .fb_tick(fbt), .ref_tick(rft), .load_clock_out(ld),
    .pipe_seq_busy(busy));
  vcs_ramdac_model model (.load_clk(ld), .edges(edges), .period_ns(period_ns),
    .high_ns(high_ns));
  initial forever #5 clk = ~clk;
  // Tick spacing, and a cycle ceiling against hangs
  always @(posedge clk)
  begin
    fb_cnt <= fbt ? 1 : fb_cnt + 1;
    rf_cnt <= rft ? 1 : rf_cnt + 1;
    if (fbt)
      fb_gap <= fb_cnt;
    if (rft)
      rf_gap <= rf_cnt;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  // ----------------------------------
  // Tasks
  // ----------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wt === 1'b1);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic end_sim();
    $display("Counts: %0d checked, %0d failed", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset();
    bus(1'b0, STAT_OFS, 32'h0);
    chk(q[4:0], 5'h00);
    chk(q[19:16], 4'h4);
    chk({fb, rf, vg, pd}, {10'h064, 7'h0a, 3'h2, 2'h0});
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    repeat (30) @(posedge clk);
    chk(period_ns, 40);
    $display("test reset done");
  endtask
  task automatic t_select();
    bus(1'b1, 8'h94, {6'h0, 1'b0, 3'h2, 2'h3, 3'h5, 7'h03, 10'h021});
    stb <= 1'b1;
    fs <= 5'h05;
    repeat (3) @(posedge clk);
    chk({fb, rf, vg, pd}, {10'h021, 7'h03, 3'h5, 2'h3});
    stb <= 1'b0;
    fs <= 5'h00;
    repeat (80) @(posedge clk);
    chk({fb, rf, vg, pd}, {10'h021, 7'h03, 3'h5, 2'h3});
    chk(fb_gap, 33);
    chk(rf_gap, 3);
    $display("test select done");
  endtask
  task automatic t_modulus();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 8'h94, {6'h0, 1'b0, i[2:0], 2'h0, 3'h2, 7'h0a, 10'h064});
      repeat (50) @(posedge clk);
      chk(period_ns, dv[i] * 10);
      chk(high_ns, dv[i] * 5);
    end
    $display("test modulus done");
  endtask
  task automatic t_float();
    fsd <= 5'h00;
    stbd <= 1'b0;
    bus(1'b1, 8'hfc, {6'h0, 1'b1, 3'h1, 2'h0, 3'h2, 7'h0a, 10'h064});
    bus(1'b0, STAT_OFS, 32'h0);
    chk(q[4:0], 5'h1f);
    e = edges;
    repeat (40) @(posedge clk);
    chk(edges - e, 0);
    chk(ld, 1'b0);
    $display("test float done");
  endtask
  task automatic t_seq();
    fsd <= 5'h1f;
    stbd <= 1'b1;
    fs <= 5'h1f;
    bus(1'b1, 8'hfc, ENTRY_RST);
    repeat (30) @(posedge clk);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        bus(1'b1, CTRL_OFS, 32'h2);
      else
        stb <= 1'b1;
      repeat (2) @(posedge clk);
      chk(busy, 1'b1);
      e = edges;
      repeat (7) @(posedge clk);
      chk(edges - e, 0);
      n = 0;
      while (busy === 1'b1 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      chk(busy, 1'b0);
      stb <= 1'b0;
      @(posedge clk);
    end
    $display("test sequence done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_select();
    t_modulus();
    t_float();
    t_seq();
    end_sim();
  end
endmodule // video_clock_select_and_load_divider_tb_top
`default_nettype wire
